// >>> rtl/isr_cmd_seq.sv
// Command interpreter for reads from up to three isolated remote sensors.
// Assumes the link engine answers each request with one reply pulse; inputs are synchronous.
//
// Notes on behaviour
// - Only codes 001 and 010 start reads; 000, 101 and reserved codes are ignored.
// - Phase 01, 10, 11 pick first, second, third pin pair and item select.
// - Trim read: trim bit 7 to buffer bit 8, bits 6:0 to 7:1.
// - Extra trim read: first byte in upper buffer byte, second in lower.
// - Temperature read: eleven bits low, upper five bits sign extended.
// - Supply level in low byte; version in high byte; other byte zero.
// - On completion command bits clear and the result buffer is valid.
// - Command-bit writes while a read is pending are ignored; flag clears still apply.
// - Parity faults set sticky flags until software writes them clear.
`timescale 1ns/10ps
module isr_cmd_seq (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        cmd_wr_i,
   input  wire logic [7:0]  cmd_wdata_i,
   output logic      [7:0]  cmd_rdata_o,
   input  wire logic [2:0]  first_sensor_item_select_i,
   input  wire logic [2:0]  second_sensor_item_select_i,
   input  wire logic [2:0]  third_sensor_item_select_i,
   output logic      [15:0] remote_result_buffer_o,
   output logic             link_req_o,
   output logic      [1:0]  link_pin_pair_o,
   output logic      [2:0]  link_cmd_o,
   output logic      [2:0]  link_item_o,
   input  wire logic        link_rsp_valid_i,
   input  wire logic [15:0] link_rsp_data_i,
   input  wire logic        link_rsp_perr_i,
   input  wire logic        link_wr_perr_i
);

   isr_pkg::isr_state_s state_reg;
   isr_pkg::isr_state_s state_next;
   isr_fmt_if           fmt_bus ();

   logic [2:0] wr_code;
   logic [1:0] wr_phase;
   logic       wr_valid;
   logic [2:0] sel_item;
   logic       done;

   assign wr_code  = cmd_wdata_i[isr_pkg::CMD_CODE_MSB:isr_pkg::CMD_CODE_LSB];
   assign wr_phase = cmd_wdata_i[isr_pkg::PHASE_MSB:isr_pkg::PHASE_LSB];
   // Reserved codes are ignored too rather than sent on
   assign wr_valid = ((wr_code == isr_pkg::CMD_TRIM) || (wr_code == isr_pkg::CMD_SENSE))
                     && (wr_phase != isr_pkg::PHASE_INVALID);
   assign done     = (state_reg.st == isr_pkg::ISR_BUSY) && link_rsp_valid_i;

   // ==========================================================
   // Phase decode
   always_comb begin
      unique case (wr_phase)
         isr_pkg::PHASE_FIRST:  sel_item = first_sensor_item_select_i;
         isr_pkg::PHASE_SECOND: sel_item = second_sensor_item_select_i;
         isr_pkg::PHASE_THIRD:  sel_item = third_sensor_item_select_i;
         default:               sel_item = isr_pkg::ITEM_SEL_RESET;
      endcase
   end

   // ==========================================================
   // Result formatter
   assign fmt_bus.cmd  = state_reg.cmd;
   assign fmt_bus.item = state_reg.item;
   assign fmt_bus.raw  = link_rsp_data_i;

   isr_result_fmt u_fmt (
      .f (fmt_bus.fmt)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      state_next     = state_reg;
      state_next.req = 1'b0;
      // Flags written as zero clear; an event in the same cycle wins
      if (cmd_wr_i && !cmd_wdata_i[isr_pkg::RD_PERR_BIT]) begin
         state_next.rd_perr = 1'b0;
      end
      if (cmd_wr_i && !cmd_wdata_i[isr_pkg::WR_PERR_BIT]) begin
         state_next.wr_perr = 1'b0;
      end
      if (link_wr_perr_i) begin
         state_next.wr_perr = 1'b1;
      end
      unique case (state_reg.st)
         isr_pkg::ISR_IDLE: begin
            if (cmd_wr_i && wr_valid) begin
               state_next.st    = isr_pkg::ISR_BUSY;
               state_next.cmd   = wr_code;
               state_next.phase = wr_phase;
               state_next.item  = sel_item;
               state_next.req   = 1'b1;
            end
         end
         isr_pkg::ISR_BUSY: begin
            // Writes to the command bits are dropped here
            if (link_rsp_valid_i) begin
               state_next.st     = isr_pkg::ISR_IDLE;
               state_next.cmd    = isr_pkg::CMD_NONE;
               state_next.result = fmt_bus.result;
               if (link_rsp_perr_i) begin
                  state_next.rd_perr = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= '{st: isr_pkg::ISR_IDLE, cmd: isr_pkg::CMD_NONE, phase: isr_pkg::PHASE_INVALID,
                        item: isr_pkg::ITEM_SEL_RESET, rd_perr: 1'b0, wr_perr: 1'b0, req: 1'b0,
                        result: isr_pkg::RESULT_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign cmd_rdata_o            = {1'b0, state_reg.rd_perr, state_reg.wr_perr, state_reg.cmd, state_reg.phase};
   assign remote_result_buffer_o = state_reg.result;
   assign link_req_o             = state_reg.req;
   assign link_pin_pair_o        = state_reg.phase;
   assign link_cmd_o             = state_reg.cmd;
   assign link_item_o            = state_reg.item;

   // ==========================================================
   // Assertions
   a_invalid_code_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_IDLE) && cmd_wr_i
      && ((wr_code == isr_pkg::CMD_NONE) || (wr_code == isr_pkg::CMD_INVALID_B))
      |=> !link_req_o && (cmd_rdata_o[4:2] == isr_pkg::CMD_NONE))
      else $error("invalid command code was not ignored");

   a_valid_cmd_starts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_IDLE) && cmd_wr_i && wr_valid
      |=> link_req_o && (link_cmd_o == $past(wr_code)) ##1 !link_req_o)
      else $error("valid command did not issue exactly one request");

   a_phase_item_pick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      link_req_o |-> link_item_o == ((link_pin_pair_o == isr_pkg::PHASE_FIRST)
         ? $past(first_sensor_item_select_i)
         : (link_pin_pair_o == isr_pkg::PHASE_SECOND) ? $past(second_sensor_item_select_i)
         : $past(third_sensor_item_select_i)))
      else $error("item select not taken from selected phase");

   a_trim_packing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_TRIM) && (state_reg.item[2:1] == isr_pkg::ITEM_BASE)
      |=> remote_result_buffer_o == {7'h00, $past(link_rsp_data_i[7:0]), 1'b0})
      else $error("trim value packed wrongly");

   a_extra_trim_pack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_TRIM) && (state_reg.item[2:1] == isr_pkg::ITEM_EXTRA_TRIM)
      |=> remote_result_buffer_o == $past(link_rsp_data_i))
      else $error("extra trim bytes packed wrongly");

   a_temp_sign_ext: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_SENSE) && (state_reg.item[2:1] == isr_pkg::ITEM_BASE)
      |=> (remote_result_buffer_o[10:0] == $past(link_rsp_data_i[10:0]))
          && (remote_result_buffer_o[15:11] == {5{remote_result_buffer_o[10]}}))
      else $error("temperature not sign extended");

   a_supply_version: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_SENSE) && (state_reg.item[2] != state_reg.item[1])
      |=> (remote_result_buffer_o == ($past(state_reg.item[1])
            ? {8'h00, $past(link_rsp_data_i[7:0])} : {$past(link_rsp_data_i[7:0]), 8'h00})))
      else $error("supply level or version packed wrongly");

   a_done_clears_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done |=> (cmd_rdata_o[4:2] == isr_pkg::CMD_NONE) && (remote_result_buffer_o == $past(fmt_bus.result)))
      else $error("command bits not cleared at completion");

   a_busy_ignores_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_BUSY) && !link_rsp_valid_i
      |=> $stable(link_cmd_o) && $stable(link_item_o) && !link_req_o)
      else $error("command write accepted while busy");

   a_rd_perr_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (done && link_rsp_perr_i) or (cmd_rdata_o[6] && !(cmd_wr_i && !cmd_wdata_i[6]))
      |=> cmd_rdata_o[6])
      else $error("read parity flag lost");

   a_wr_perr_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      link_wr_perr_i or (cmd_rdata_o[5] && !(cmd_wr_i && !cmd_wdata_i[5])) |=> cmd_rdata_o[5])
      else $error("write parity flag lost");

   a_reserved_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_IDLE) && cmd_wr_i
      && (wr_code != isr_pkg::CMD_NONE) && (wr_code != isr_pkg::CMD_TRIM)
      && (wr_code != isr_pkg::CMD_SENSE) && (wr_code != isr_pkg::CMD_INVALID_B)
      |=> !link_req_o && (cmd_rdata_o[4:2] == isr_pkg::CMD_NONE))
      else $error("reserved command code was not ignored");

   a_phase_zero_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_IDLE) && cmd_wr_i && (wr_phase == isr_pkg::PHASE_INVALID)
      |=> !link_req_o && (cmd_rdata_o[4:2] == isr_pkg::CMD_NONE))
      else $error("phase selector zero was not ignored");

   a_pair_from_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      link_req_o |-> link_pin_pair_o == $past(wr_phase))
      else $error("pin pair not taken from phase selector");

   a_result_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !done |=> $stable(remote_result_buffer_o))
      else $error("result buffer changed without a completion");

   c_trim_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_TRIM));
   c_temp_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      done && (state_reg.cmd == isr_pkg::CMD_SENSE) && (state_reg.item[2:1] == isr_pkg::ITEM_BASE));
   c_busy_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg.st == isr_pkg::ISR_BUSY) && cmd_wr_i && wr_valid);
   c_parity_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      done && link_rsp_perr_i);
   c_third_phase: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      link_req_o && (link_pin_pair_o == isr_pkg::PHASE_THIRD));

endmodule

// >>> rtl/isr_pkg.sv
// Shared constants and types for the isolated sensor read command block.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
package isr_pkg;

   // ==========================================================
   // Clock
   localparam int unsigned CLK_HZ            = 20_000_000;

   // ==========================================================
   // Command byte layout
   localparam int unsigned CMD_BYTE_W        = 8;
   localparam int unsigned CMD_CODE_LSB      = 2;
   localparam int unsigned CMD_CODE_MSB      = 4;
   localparam int unsigned PHASE_LSB         = 0;
   localparam int unsigned PHASE_MSB         = 1;
   localparam int unsigned WR_PERR_BIT       = 5;
   localparam int unsigned RD_PERR_BIT       = 6;

   // ==========================================================
   // Command codes
   localparam logic [2:0] CMD_NONE           = 3'h0;
   localparam logic [2:0] CMD_TRIM           = 3'h1;
   localparam logic [2:0] CMD_SENSE          = 3'h2;
   localparam logic [2:0] CMD_INVALID_B      = 3'h5;

   // ==========================================================
   // Phase selector codes
   localparam logic [1:0] PHASE_INVALID      = 2'h0;
   localparam logic [1:0] PHASE_FIRST        = 2'h1;
   localparam logic [1:0] PHASE_SECOND       = 2'h2;
   localparam logic [1:0] PHASE_THIRD        = 2'h3;

   // ==========================================================
   // Item select codes, upper two bits only (least bit ignored)
   localparam logic [1:0] ITEM_BASE          = 2'h0;
   localparam logic [1:0] ITEM_SUPPLY        = 2'h1;
   localparam logic [1:0] ITEM_VERSION       = 2'h2;
   localparam logic [1:0] ITEM_EXTRA_TRIM    = 2'h3;

   // ==========================================================
   // Result layout and reset values
   localparam int unsigned RESULT_W          = 16;
   localparam int unsigned TEMP_W            = 11;
   localparam logic [15:0] RESULT_RESET      = 16'h0000;
   localparam logic [2:0]  ITEM_SEL_RESET    = 3'h0;

   typedef enum logic [0:0] {
      ISR_IDLE = 1'b0,
      ISR_BUSY = 1'b1
   } isr_state_e;

   typedef struct packed {
      isr_state_e  st;
      logic [2:0]  cmd;
      logic [1:0]  phase;
      logic [2:0]  item;
      logic        rd_perr;
      logic        wr_perr;
      logic        req;
      logic [15:0] result;
   } isr_state_s;

endpackage

// >>> rtl/isr_fmt_if.sv
// Carrier between the command sequencer and the result formatter.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/10ps
interface isr_fmt_if;
   logic [2:0]  cmd;
   logic [2:0]  item;
   logic [15:0] raw;
   logic [15:0] result;

   modport seq (output cmd, output item, output raw, input result);
   modport fmt (input cmd, input item, input raw, output result);
endinterface

// >>> rtl/isr_result_fmt.sv
// Packs raw sensor reply data into the 16-bit result buffer layout.
// Assumes the raw reply carries bytes as the sensor sends them: one item in the low byte,
// extra trim pair high then low, temperature in the low eleven bits.
`timescale 1ns/10ps
module isr_result_fmt (
   isr_fmt_if.fmt f
);

   // ==========================================================
   // Formatting
   always_comb begin
      f.result = isr_pkg::RESULT_RESET;
      unique case (f.cmd)
         isr_pkg::CMD_TRIM: begin
            if (f.item[2:1] == isr_pkg::ITEM_BASE) begin
               f.result = {7'h00, f.raw[7:0], 1'b0};
            end else if (f.item[2:1] == isr_pkg::ITEM_EXTRA_TRIM) begin
               f.result = f.raw;
            end
         end
         isr_pkg::CMD_SENSE: begin
            unique case (f.item[2:1])
               isr_pkg::ITEM_BASE:    f.result = {{5{f.raw[10]}}, f.raw[10:0]};
               isr_pkg::ITEM_SUPPLY:  f.result = {8'h00, f.raw[7:0]};
               isr_pkg::ITEM_VERSION: f.result = {f.raw[7:0], 8'h00};
               default:               f.result = isr_pkg::RESULT_RESET;
            endcase
         end
         // Undefined pairings leave a zero result
         default: f.result = isr_pkg::RESULT_RESET;
      endcase
   end

endmodule

// >>> tb/isr_sensor_model.sv
// Behavioural remote sensor behind the link request/reply ports.
// Assumes the request is a one-cycle pulse and command/item stand while busy.
`timescale 1ns/10ps
module isr_sensor_model #(
   parameter logic [7:0]  TRIM = 8'h81,
   parameter logic [15:0] XTRM = 16'hA55A,
   parameter logic [10:0] TEMP = 11'h5A5,
   parameter logic [7:0]  SUPL = 8'h3C,
   parameter logic [7:0]  VERS = 8'hC3
) (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [2:0]  cmd_i,
   input  wire logic [2:0]  item_i,
   input  wire logic [3:0]  dly_i,
   input  wire logic        perr_i,
   output logic             valid_o,
   output logic      [15:0] data_o,
   output logic             perr_o
);
   logic [15:0] raw;
   // ==========================================
   // Reply engine
   initial begin
      valid_o = 1'b0;
      data_o  = 16'h0000;
      perr_o  = 1'b0;
      forever begin
         @(negedge clk_i);
         if (req_i === 1'b1) begin
            repeat (dly_i) @(negedge clk_i);
            // Junk above the item so the packer must not pass it through
            case ({cmd_i, item_i[2:1]})
               5'h04:   raw = {8'hE7, TRIM};
               5'h07:   raw = XTRM;
               5'h08:   raw = {5'h0A, TEMP};
               5'h09:   raw = {8'hEE, SUPL};
               5'h0A:   raw = {8'h99, VERS};
               default: raw = 16'h0000;
            endcase
            valid_o = 1'b1;
            data_o  = raw;
            perr_o  = perr_i;
            @(negedge clk_i);
            // Released data shows garbage, not the last value
            valid_o = 1'b0;
            data_o  = ~raw;
            perr_o  = 1'b0;
         end
      end
   end
endmodule

// >>> tb/isr_cmd_seq_tb.sv
// Self-checking bench for the command interpreter.
// Assumes the sensor model answers each request; inputs change on falling edges.
`timescale 1ns/10ps
module isr_cmd_seq_tb;
   logic        clk_i, rst_n_i, cmd_wr, perr, wperr, req, pvld, rperr;
   logic [7:0]  wdata, rdata;
   logic [2:0]  sel1, sel2, sel3, lcmd, litem;
   logic [1:0]  pair;
   logic [3:0]  dly;
   logic [15:0] res, pdata;
   int          n_fail, checked, n_req;

   isr_cmd_seq u_isr_cmd_seq (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr), .cmd_wdata_i(wdata),
      .cmd_rdata_o(rdata), .first_sensor_item_select_i(sel1), .second_sensor_item_select_i(sel2),
      .third_sensor_item_select_i(sel3), .remote_result_buffer_o(res), .link_req_o(req),
      .link_pin_pair_o(pair), .link_cmd_o(lcmd), .link_item_o(litem), .link_rsp_valid_i(pvld),
      .link_rsp_data_i(pdata), .link_rsp_perr_i(rperr), .link_wr_perr_i(wperr));
   isr_sensor_model u_isr_sensor_model (.clk_i(clk_i), .req_i(req), .cmd_i(lcmd), .item_i(litem),
      .dly_i(dly), .perr_i(perr), .valid_o(pvld), .data_o(pdata), .perr_o(rperr));

   // ==========================================
   // Clock, request count, watchdog
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(negedge clk_i) if (req === 1'b1) n_req++;
   initial begin
      repeat (3000) @(posedge clk_i);
      n_fail++;
      stop_test();
   end

   // ==========================================
   // Shared tasks
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk16({8'h00, got}, {8'h00, exp});
   endtask
   task automatic wr(input logic [7:0] d);
      @(negedge clk_i);
      cmd_wr = 1'b1;
      wdata  = d;
      @(negedge clk_i);
      cmd_wr = 1'b0;
   endtask
   task automatic wait_done;
      int i;
      for (i = 0; i < 40 && rdata[4:2] !== 3'h0; i++) @(negedge clk_i);
      chk8({5'h00, rdata[4:2]}, 8'h00);
   endtask
   // Flag bits written 1 so a read never clears them
   task automatic rd(input logic [2:0] c, input logic [1:0] p, input logic [15:0] e);
      wr({3'h3, c, p});
      chk8({3'h0, rdata[4:0]}, {3'h0, c, p});
      chk8({5'h00, lcmd}, {5'h00, c});
      wait_done();
      chk16(res, e);
      chk8({5'h00, lcmd}, 8'h00);
      chk8({6'h00, pair}, {6'h00, p});
   endtask

   // ==========================================
   // Scenarios
   task automatic t_formats;
      sel1 = 3'h1;
      rd(3'h1, 2'h1, 16'h0102);
      sel1 = 3'h6;
      rd(3'h1, 2'h1, 16'hA55A);
      sel1 = 3'h0;
      rd(3'h2, 2'h1, 16'hFDA5);
      sel1 = 3'h3;
      rd(3'h2, 2'h1, 16'h003C);
      sel1 = 3'h5;
      rd(3'h2, 2'h1, 16'hC300);
      $display("test formats done");
   endtask
   task automatic t_phase;
      sel1 = 3'h1;
      sel2 = 3'h2;
      sel3 = 3'h4;
      rd(3'h2, 2'h1, 16'hFDA5);
      chk8({5'h00, litem}, 8'h01);
      rd(3'h2, 2'h2, 16'h003C);
      chk8({5'h00, litem}, 8'h02);
      rd(3'h2, 2'h3, 16'hC300);
      chk8({5'h00, litem}, 8'h04);
      $display("test phase done");
   endtask
   task automatic t_refuse;
      int k, n0;
      logic [2:0] bad [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
      n0 = n_req;
      for (k = 0; k < 6; k++) begin
         wr({3'h3, bad[k], 2'h1});
         repeat (3) @(negedge clk_i);
         chk8({5'h00, rdata[4:2]}, 8'h00);
      end
      wr(8'h64);
      repeat (3) @(negedge clk_i);
      chk8({5'h00, rdata[4:2]}, 8'h00);
      chk16(16'(n_req - n0), 16'h0000);
      $display("test refuse done");
   endtask
   task automatic t_busy;
      int n0;
      n0 = n_req;
      dly = 4'h8;
      sel2 = 3'h2;
      wr(8'h6A);
      wr(8'h67);
      chk8({3'h0, rdata[4:0]}, 8'h0A);
      wait_done();
      chk16(res, 16'h003C);
      chk16(16'(n_req - n0), 16'h0001);
      dly = 4'h0;
      rd(3'h1, 2'h1, 16'h0102);
      $display("test busy done");
   endtask
   task automatic t_perr;
      perr = 1'b1;
      rd(3'h1, 2'h1, 16'h0102);
      perr = 1'b0;
      rd(3'h1, 2'h1, 16'h0102);
      chk8({7'h00, rdata[6]}, 8'h01);
      @(negedge clk_i);
      wperr = 1'b1;
      @(negedge clk_i);
      wperr = 1'b0;
      repeat (4) @(negedge clk_i);
      chk8({6'h00, rdata[6:5]}, 8'h03);
      wr(8'h00);
      @(negedge clk_i);
      chk8({6'h00, rdata[6:5]}, 8'h00);
      $display("test parity done");
   endtask

   task automatic stop_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      {rst_n_i, cmd_wr, perr, wperr, wdata, sel1, sel2, sel3, dly} = '0;
      n_fail = 0;
      checked = 0;
      n_req = 0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk8(rdata, 8'h00);
      chk16(res, 16'h0000);
      t_formats();
      t_phase();
      t_refuse();
      t_busy();
      t_perr();
      stop_test();
   end
endmodule
